// *** bench/sgm_host_model.sv ***
// Host processor model driving the three bus control lines and the shared data bus.
// Assumes the bench resolves the shared bus and feeds the resolved level back here.
`default_nettype none
module sgm_host_model (
    input  wire logic       ref_clk,
    output logic            bus_direction_ctl,
    output logic            bus_control_one,
    output logic            bus_control_two,
    output logic      [7:0] bus_to_dev,
    input  wire logic [7:0] bus_from_dev,
    input  wire logic       dev_drives
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {bus_direction_ctl, bus_control_one} = 2'b00;
        bus_control_two = 1'b1;
        bus_to_dev      = 8'h00;
    end
    // One bus state held for n cycles, then inactive with the complement of the data driven
    task automatic cycle(input logic [1:0] st, input logic [7:0] d, input int n, output logic [8:0] q);
        @(negedge ref_clk);
        {bus_direction_ctl, bus_control_one} = st;
        bus_to_dev = d;
        repeat (n) @(negedge ref_clk);
        q = {dev_drives, bus_from_dev};
        {bus_direction_ctl, bus_control_one} = 2'b00;
        bus_to_dev = ~d;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [8:0] q;
        cycle(2'b11, {4'h0, a}, 1, q);
        cycle(2'b10, d, 1, q);
    endtask
    task automatic rd(input logic [3:0] a, output logic [8:0] q);
        cycle(2'b11, {4'h0, a}, 1, q);
        cycle(2'b01, 8'h00, 2, q);
    endtask
endmodule
`default_nettype wire

// *** bench/sound_mixer_envelope_ioport_tb.sv ***
// Self-checking bench: registers, mixer, levels, envelope shapes and ports.
// Assumes sgm_map.svh, sgm_pkg, sgm_top and sgm_host_model are compiled first.
`default_nettype none
`include "sgm_map.svh"
module sound_mixer_envelope_ioport_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        bus_dir, bus_one, bus_two, doe, pa_oe, pb_oe;
    logic  [7:0] hdrv, dout, da, pa_out, pb_out, pin_a, pin_b, e;
    logic  [7:0] ext_a   = 8'h00;
    logic  [7:0] ext_b   = 8'h00;
    logic  [2:0] tone    = 3'h0;
    logic  [2:0] noise   = 3'h0;
    logic  [2:0] mix;
    logic [11:0] lvl;
    logic  [3:0] env;
    int          mismatches = 0;
    int          n_checks   = 0;
    int          cyc        = 0;
    int          tick       = 0;
    int          n;
    logic  [3:0] n_shape [10] = '{4'h0, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    always #12.5 ref_clk = ~ref_clk;
    assign da    = doe ? dout : hdrv;
    assign pin_a = pa_oe ? pa_out : ext_a;
    assign pin_b = pb_oe ? pb_out : ext_b;
    sgm_top dut (
        .ref_clk                (ref_clk),
        .rst                    (rst),
        .bus_direction_ctl      (bus_dir),
        .bus_control_one        (bus_one),
        .bus_control_two        (bus_two),
        .host_addr_data_bus_in  (da),
        .host_addr_data_bus_out (dout),
        .host_addr_data_bus_oe  (doe),
        .tone_in                (tone),
        .noise_in               (noise),
        .mixer_out              (mix),
        .channel_level          (lvl),
        .envelope_level_out     (env),
        .general_port_a_in      (pin_a),
        .general_port_a_out     (pa_out),
        .general_port_a_oe      (pa_oe),
        .general_port_b_in      (pin_b),
        .general_port_b_out     (pb_out),
        .general_port_b_oe      (pb_oe)
    );
    sgm_host_model host (
        .ref_clk           (ref_clk),
        .bus_direction_ctl (bus_dir),
        .bus_control_one   (bus_one),
        .bus_control_two   (bus_two),
        .bus_to_dev        (hdrv),
        .bus_from_dev      (da),
        .dev_drives        (doe)
    );
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc  <= rst ? 0 : cyc + 1;
        tick <= tick + 1;
        if (tick == 90000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
        logic [8:0] q;
        host.rd(a, q);
        check(what, {8'h01, exp}, {7'h00, q});
    endtask
    // Level expected k steps after a shape write
    function automatic logic [3:0] env_exp(input logic [3:0] s, input int k);
        logic up;
        up = s[`SGM_SHAPE_ATTACK] ^ (s[`SGM_SHAPE_ALTERNATE] & (((k / 16) % 2) == 1));
        if (k >= 16 && !s[`SGM_SHAPE_CONTINUE]) return 4'h0;
        if (k >= 16 && s[`SGM_SHAPE_HOLD]) return (s[`SGM_SHAPE_ATTACK] ^ s[`SGM_SHAPE_ALTERNATE]) ? 4'hf : 4'h0;
        return up ? 4'(k % 16) : 4'(15 - (k % 16));
    endfunction
    task automatic wait_change(output int n);
        logic [3:0] v;
        v = env;
        n = 0;
        while (env === v && n < 1000) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    // Write the shape away from a prescaler wrap, then sample mid-step
    task automatic run_shape(input logic [3:0] s);
        int m;
        while (cyc % 256 != 100) @(negedge ref_clk);
        host.wr(`SGM_REG_ENVELOPE_SHAPE, {4'h0, s});
        repeat (3) @(negedge ref_clk);
        check("env start", env_exp(s, 0), env);
        wait_change(m);
        repeat (128) @(negedge ref_clk);
        for (int k = 1; k <= 20; k++) begin
            check("env level", env_exp(s, k), env);
            check("chan b env", env_exp(s, k), lvl[7:4]);
            repeat (256) @(negedge ref_clk);
        end
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        check("reset out", 16'h000f, {pa_out, pa_oe, pb_oe, doe, 1'b0, env});
        check("reset lvl", 16'h0000, {4'h0, lvl});
        for (int a = 6; a < 16; a++) rd_chk("reg reset", 4'(a), 8'h00);
        for (int a = 5; a < 16; a++) host.wr(4'(a), 8'hff);
        for (int a = 5; a < 16; a++) begin
            e = (a < 7) ? 8'h00 : (a >= 8 && a <= 10) ? 8'h1f : (a == 13) ? 8'h0f : 8'hff;
            rd_chk("reg mask", 4'(a), e);
        end
        for (int lv = 0; lv < 16; lv++) begin
            host.wr(`SGM_REG_CHANNEL_A_AMPLITUDE, 8'(lv));
            host.wr(`SGM_REG_CHANNEL_C_AMPLITUDE, 8'(15 - lv));
            @(negedge ref_clk);
            check("fixed lvl", {8'h00, 4'(15 - lv), 4'(lv)}, {4'h0, lvl[11:8], lvl[3:0]});
        end
        host.wr(`SGM_REG_CHANNEL_A_AMPLITUDE, 8'h0f);
        host.wr(`SGM_REG_CHANNEL_B_AMPLITUDE, 8'h07);
        host.wr(`SGM_REG_CHANNEL_C_AMPLITUDE, 8'h00);
        for (int en = 0; en < 64; en++) begin
            host.wr(`SGM_REG_MIXER_PORT_ENABLE, 8'(en));
            for (int tn = 0; tn < 64; tn++) begin
                @(negedge ref_clk) {noise, tone} = 6'(tn);
                repeat (2) @(negedge ref_clk);
                e = {5'h00, (tone | 3'(en)) & (noise | 3'(en >> 3))};
                check("mixer", {8'h00, e}, {13'h0000, mix});
            end
        end
        check("level kept", 16'h007f, {4'h0, lvl});
        @(negedge ref_clk) ext_b = 8'hc3;
        host.wr(`SGM_REG_MIXER_PORT_ENABLE, 8'h40);
        host.wr(`SGM_REG_PORT_A_DATA_STORE, 8'h5a);
        @(negedge ref_clk);
        check("port a out", 16'h5a02, {pa_out, 6'h00, pa_oe, pb_oe});
        rd_chk("port b in", `SGM_REG_PORT_B_DATA_STORE, 8'hc3);
        host.wr(`SGM_REG_PORT_B_DATA_STORE, 8'h11);
        @(negedge ref_clk) ext_b = 8'h3c;
        repeat (2) @(negedge ref_clk);
        rd_chk("port b follow", `SGM_REG_PORT_B_DATA_STORE, 8'h3c);
        rd_chk("port a held", `SGM_REG_PORT_A_DATA_STORE, 8'h5a);
        check("level undisturbed", 16'h007f, {4'h0, lvl});
        host.wr(`SGM_REG_MIXER_PORT_ENABLE, 8'h80);
        repeat (2) @(negedge ref_clk);
        check("port swap", 16'h3c01, {pb_out, 6'h00, pa_oe, pb_oe});
        host.wr(`SGM_REG_CHANNEL_B_AMPLITUDE, 8'h1a);
        host.wr(`SGM_REG_ENVELOPE_PERIOD_COARSE, 8'h00);
        host.wr(`SGM_REG_ENVELOPE_PERIOD_FINE, 8'h01);
        foreach (n_shape[i]) run_shape(n_shape[i]);
        host.wr(`SGM_REG_ENVELOPE_PERIOD_FINE, 8'h03);
        host.wr(`SGM_REG_ENVELOPE_SHAPE, 8'h08);
        // Restart, then an unaligned first step; only the third change spans a full period
        wait_change(n);
        wait_change(n);
        wait_change(n);
        check("env interval", 16'h0300, 16'(n));
        @(negedge ref_clk) rst = 1'b1;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        check("second reset", 16'h0000, {pa_out, pb_out});
        final_report();
    end
endmodule
`default_nettype wire

// *** common/sgm_map.svh ***
// Register numbers, field positions, reset values and divider constants of the mixer/envelope/port block.
// Assumes an 8-bit multiplexed host bus carrying register numbers 0 to 15.
`ifndef SGM_MAP_SVH
`define SGM_MAP_SVH
`define SGM_REG_MIXER_PORT_ENABLE      4'h7
`define SGM_REG_CHANNEL_A_AMPLITUDE    4'h8
`define SGM_REG_CHANNEL_B_AMPLITUDE    4'h9
`define SGM_REG_CHANNEL_C_AMPLITUDE    4'ha
`define SGM_REG_ENVELOPE_PERIOD_FINE   4'hb
`define SGM_REG_ENVELOPE_PERIOD_COARSE 4'hc
`define SGM_REG_ENVELOPE_SHAPE         4'hd
`define SGM_REG_PORT_A_DATA_STORE      4'he
`define SGM_REG_PORT_B_DATA_STORE      4'hf
`define SGM_MIX_TONE_LSB               0
`define SGM_MIX_NOISE_LSB              3
`define SGM_MIX_PORT_A_DIR             6
`define SGM_MIX_PORT_B_DIR             7
`define SGM_AMP_MODE_BIT               4
`define SGM_SHAPE_HOLD                 0
`define SGM_SHAPE_ALTERNATE            1
`define SGM_SHAPE_ATTACK               2
`define SGM_SHAPE_CONTINUE             3
`define SGM_RESET_BYTE                 8'h00
`define SGM_PRESCALE_DIV               256
`endif

// *** common/sgm_pkg.sv ***
// Types shared by the mixer/envelope/port block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package sgm_pkg;
    typedef enum logic [1:0] {
        SGM_BUS_INACTIVE = 2'b00,
        SGM_BUS_READ     = 2'b01,
        SGM_BUS_WRITE    = 2'b10,
        SGM_BUS_LATCH    = 2'b11
    } sgm_bus_op_t;
    typedef enum logic [1:0] {
        SGM_ENV_RUN      = 2'b00,
        SGM_ENV_HOLD     = 2'b01
    } sgm_env_state_t;
endpackage
`default_nettype wire

// *** hw/sgm_channel.sv ***
// One channel: mixer gating and amplitude selection.
// Assumes tone, noise and envelope level are synchronous to ref_clk.
`default_nettype none
`include "sgm_map.svh"
module sgm_channel
    import sgm_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       tone_in,
    input  wire logic       noise_in,
    input  wire logic       tone_enable_n,
    input  wire logic       noise_enable_n,
    input  wire logic [4:0] amplitude,
    input  wire logic [3:0] envelope_level_out,
    output logic            mixer_out,
    output logic      [3:0] level_out
);
    // Disabled source reads as high, so a channel with both off stays a steady level
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mixer_out <= 1'b0;
        end else begin
            mixer_out <= (tone_in | tone_enable_n) & (noise_in | noise_enable_n);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            level_out <= 4'h0;
        end else if (amplitude[`SGM_AMP_MODE_BIT]) begin
            level_out <= envelope_level_out;
        end else begin
            level_out <= amplitude[3:0];
        end
    end

    property p_mode_select;
        @(posedge ref_clk) disable iff (rst)
        !amplitude[`SGM_AMP_MODE_BIT] |=> (level_out == $past(amplitude[3:0]));
    endproperty
    a_mode_select: assert property (p_mode_select) else $error("fixed level not passed");

    property p_env_select;
        @(posedge ref_clk) disable iff (rst)
        amplitude[`SGM_AMP_MODE_BIT] |=> (level_out == $past(envelope_level_out));
    endproperty
    a_env_select: assert property (p_env_select) else $error("envelope level not passed");

    property p_both_off;
        @(posedge ref_clk) disable iff (rst)
        (tone_enable_n && noise_enable_n) |=> mixer_out;
    endproperty
    a_both_off: assert property (p_both_off) else $error("disabled channel not steady high");
endmodule
`default_nettype wire

// *** hw/sgm_top.sv ***
// Mixer, amplitude control, envelope generator and two I/O port stores of a three-channel sound generator.
// Assumes host bus controls are synchronous to ref_clk; tone and noise arrive from generators elsewhere.
`default_nettype none
`include "sgm_map.svh"
module sgm_top
    import sgm_pkg::*;
#(
    parameter int CHANNELS = 3
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       bus_direction_ctl,
    input  wire logic       bus_control_one,
    input  wire logic       bus_control_two,
    input  wire logic [7:0] host_addr_data_bus_in,
    output logic      [7:0] host_addr_data_bus_out,
    output logic            host_addr_data_bus_oe,
    input  wire logic [2:0] tone_in,
    input  wire logic [2:0] noise_in,
    output logic      [2:0] mixer_out,
    output logic     [11:0] channel_level,
    output logic      [3:0] envelope_level_out,
    input  wire logic [7:0] general_port_a_in,
    output logic      [7:0] general_port_a_out,
    output logic            general_port_a_oe,
    input  wire logic [7:0] general_port_b_in,
    output logic      [7:0] general_port_b_out,
    output logic            general_port_b_oe
);
    // Three amplitude registers and a three-bit mixer field fix the channel count
    if (CHANNELS != 3) begin : g_bad_channels
        $error("sgm_top serves exactly three channels");
    end

    sgm_bus_op_t bus_op;
    logic [3:0]  addr_q;
    logic [7:0]  mixer_port_enable_q;
    logic [4:0]  channel_a_amplitude_q;
    logic [4:0]  channel_b_amplitude_q;
    logic [4:0]  channel_c_amplitude_q;
    logic [7:0]  envelope_period_fine_q;
    logic [7:0]  envelope_period_coarse_q;
    logic [3:0]  envelope_shape_q;
    logic [7:0]  port_a_data_store_q;
    logic [7:0]  port_b_data_store_q;
    logic        write_en;
    logic        shape_write;
    logic [15:0] envelope_period_value;

    // Bus state from the three control lines; bus_control_two low folds to inactive
    always_comb begin
        bus_op = SGM_BUS_INACTIVE;
        if (bus_control_two) begin
            unique case ({bus_direction_ctl, bus_control_one})
                2'b00: bus_op = SGM_BUS_INACTIVE;
                2'b01: bus_op = SGM_BUS_READ;
                2'b10: bus_op = SGM_BUS_WRITE;
                2'b11: bus_op = SGM_BUS_LATCH;
            endcase
        end
    end

    // Upper address nibble must be zero to reach a register; otherwise register 0 is latched
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            addr_q <= 4'h0;
        end else if (bus_op == SGM_BUS_LATCH) begin
            addr_q <= host_addr_data_bus_in[7:4] == 4'h0 ? host_addr_data_bus_in[3:0] : 4'h0;
        end
    end

    assign write_en    = (bus_op == SGM_BUS_WRITE);
    assign shape_write = write_en && addr_q == `SGM_REG_ENVELOPE_SHAPE;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mixer_port_enable_q      <= `SGM_RESET_BYTE;
            channel_a_amplitude_q    <= 5'h00;
            channel_b_amplitude_q    <= 5'h00;
            channel_c_amplitude_q    <= 5'h00;
            envelope_period_fine_q   <= `SGM_RESET_BYTE;
            envelope_period_coarse_q <= `SGM_RESET_BYTE;
            envelope_shape_q         <= 4'h0;
        end else if (write_en) begin
            unique case (addr_q)
                `SGM_REG_MIXER_PORT_ENABLE:      mixer_port_enable_q      <= host_addr_data_bus_in;
                `SGM_REG_CHANNEL_A_AMPLITUDE:    channel_a_amplitude_q    <= host_addr_data_bus_in[4:0];
                `SGM_REG_CHANNEL_B_AMPLITUDE:    channel_b_amplitude_q    <= host_addr_data_bus_in[4:0];
                `SGM_REG_CHANNEL_C_AMPLITUDE:    channel_c_amplitude_q    <= host_addr_data_bus_in[4:0];
                `SGM_REG_ENVELOPE_PERIOD_FINE:   envelope_period_fine_q   <= host_addr_data_bus_in;
                `SGM_REG_ENVELOPE_PERIOD_COARSE: envelope_period_coarse_q <= host_addr_data_bus_in;
                `SGM_REG_ENVELOPE_SHAPE:         envelope_shape_q         <= host_addr_data_bus_in[3:0];
                default: ;
            endcase
        end
    end

    // Port stores: input mode loads from pins every cycle; writes land only in output mode
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            port_a_data_store_q <= `SGM_RESET_BYTE;
        end else if (!mixer_port_enable_q[`SGM_MIX_PORT_A_DIR]) begin
            port_a_data_store_q <= general_port_a_in;
        end else if (write_en && addr_q == `SGM_REG_PORT_A_DATA_STORE) begin
            port_a_data_store_q <= host_addr_data_bus_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            port_b_data_store_q <= `SGM_RESET_BYTE;
        end else if (!mixer_port_enable_q[`SGM_MIX_PORT_B_DIR]) begin
            port_b_data_store_q <= general_port_b_in;
        end else if (write_en && addr_q == `SGM_REG_PORT_B_DATA_STORE) begin
            port_b_data_store_q <= host_addr_data_bus_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            general_port_a_out <= 8'h00;
            general_port_a_oe  <= 1'b0;
            general_port_b_out <= 8'h00;
            general_port_b_oe  <= 1'b0;
        end else begin
            general_port_a_out <= port_a_data_store_q;
            general_port_a_oe  <= mixer_port_enable_q[`SGM_MIX_PORT_A_DIR];
            general_port_b_out <= port_b_data_store_q;
            general_port_b_oe  <= mixer_port_enable_q[`SGM_MIX_PORT_B_DIR];
        end
    end

    // Read data driven from the cycle after the read state begins to the cycle after it ends; unused numbers read zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            host_addr_data_bus_out <= 8'h00;
            host_addr_data_bus_oe  <= 1'b0;
        end else begin
            host_addr_data_bus_oe <= (bus_op == SGM_BUS_READ);
            unique case (addr_q)
                `SGM_REG_MIXER_PORT_ENABLE:      host_addr_data_bus_out <= mixer_port_enable_q;
                `SGM_REG_CHANNEL_A_AMPLITUDE:    host_addr_data_bus_out <= {3'h0, channel_a_amplitude_q};
                `SGM_REG_CHANNEL_B_AMPLITUDE:    host_addr_data_bus_out <= {3'h0, channel_b_amplitude_q};
                `SGM_REG_CHANNEL_C_AMPLITUDE:    host_addr_data_bus_out <= {3'h0, channel_c_amplitude_q};
                `SGM_REG_ENVELOPE_PERIOD_FINE:   host_addr_data_bus_out <= envelope_period_fine_q;
                `SGM_REG_ENVELOPE_PERIOD_COARSE: host_addr_data_bus_out <= envelope_period_coarse_q;
                `SGM_REG_ENVELOPE_SHAPE:         host_addr_data_bus_out <= {4'h0, envelope_shape_q};
                `SGM_REG_PORT_A_DATA_STORE:      host_addr_data_bus_out <= port_a_data_store_q;
                `SGM_REG_PORT_B_DATA_STORE:      host_addr_data_bus_out <= port_b_data_store_q;
                default:                         host_addr_data_bus_out <= 8'h00;
            endcase
        end
    end

    // Envelope timing: prescaler by 256, then period divider
    localparam logic [7:0] PRESCALE_LAST = 8'(`SGM_PRESCALE_DIV - 1);
    logic [7:0]  prescale_q;
    logic [15:0] period_cnt_q;
    logic        prescale_tick;
    logic        env_step;
    assign envelope_period_value = {envelope_period_coarse_q, envelope_period_fine_q};
    assign prescale_tick = (prescale_q == PRESCALE_LAST);
    // Period zero is served as one
    assign env_step = prescale_tick && (period_cnt_q + 16'h0001 >= envelope_period_value);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prescale_q <= 8'h00;
        end else begin
            prescale_q <= prescale_q + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || shape_write) begin
            period_cnt_q <= 16'h0000;
        end else if (env_step) begin
            period_cnt_q <= 16'h0000;
        end else if (prescale_tick) begin
            period_cnt_q <= period_cnt_q + 16'h0001;
        end
    end

    // Envelope counter; up_q is the current direction
    sgm_env_state_t env_state_q;
    logic [3:0]     env_cnt_q;
    logic           up_q;
    logic           start_up;
    assign start_up = host_addr_data_bus_in[`SGM_SHAPE_ATTACK];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            env_state_q <= SGM_ENV_RUN;
            env_cnt_q   <= 4'hf;
            up_q        <= 1'b0;
        end else if (shape_write) begin
            env_state_q <= SGM_ENV_RUN;
            env_cnt_q   <= start_up ? 4'h0 : 4'hf;
            up_q        <= start_up;
        end else if (env_step && env_state_q == SGM_ENV_RUN) begin
            if (env_cnt_q != (up_q ? 4'hf : 4'h0)) begin
                env_cnt_q <= up_q ? env_cnt_q + 4'h1 : env_cnt_q - 4'h1;
            end else if (!envelope_shape_q[`SGM_SHAPE_CONTINUE]) begin
                env_cnt_q   <= 4'h0;
                env_state_q <= SGM_ENV_HOLD;
            end else if (envelope_shape_q[`SGM_SHAPE_HOLD]) begin
                env_state_q <= SGM_ENV_HOLD;
                if (envelope_shape_q[`SGM_SHAPE_ALTERNATE]) begin
                    env_cnt_q <= up_q ? 4'h0 : 4'hf;
                end
            end else if (envelope_shape_q[`SGM_SHAPE_ALTERNATE]) begin
                up_q <= !up_q;
            end else begin
                env_cnt_q <= up_q ? 4'h0 : 4'hf;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            envelope_level_out <= 4'hf;
        end else begin
            envelope_level_out <= env_cnt_q;
        end
    end

    logic [4:0] amp_sel [CHANNELS];
    assign amp_sel[0] = channel_a_amplitude_q;
    assign amp_sel[1] = channel_b_amplitude_q;
    assign amp_sel[2] = channel_c_amplitude_q;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
            sgm_channel u_channel (
                .ref_clk            (ref_clk),
                .rst                (rst),
                .tone_in            (tone_in[ch]),
                .noise_in           (noise_in[ch]),
                .tone_enable_n      (mixer_port_enable_q[`SGM_MIX_TONE_LSB + ch]),
                .noise_enable_n     (mixer_port_enable_q[`SGM_MIX_NOISE_LSB + ch]),
                .amplitude          (amp_sel[ch]),
                .envelope_level_out (envelope_level_out),
                .mixer_out          (mixer_out[ch]),
                .level_out          (channel_level[ch*4 +: 4])
            );
        end
    endgenerate

    property p_port_dir;
        @(posedge ref_clk) disable iff (rst)
        ##1 general_port_a_oe == $past(mixer_port_enable_q[`SGM_MIX_PORT_A_DIR]);
    endproperty
    a_port_dir: assert property (p_port_dir) else $error("port A direction wrong");

    property p_input_follow;
        @(posedge ref_clk) disable iff (rst)
        !mixer_port_enable_q[`SGM_MIX_PORT_B_DIR] ##1 !$past(rst) |-> port_b_data_store_q == $past(general_port_b_in);
    endproperty
    a_input_follow: assert property (p_input_follow) else $error("port B store not following pins");

    property p_output_keep;
        @(posedge ref_clk) disable iff (rst)
        (mixer_port_enable_q[`SGM_MIX_PORT_A_DIR] && !(write_en && addr_q == `SGM_REG_PORT_A_DATA_STORE))
            |=> $stable(port_a_data_store_q);
    endproperty
    a_output_keep: assert property (p_output_keep) else $error("port A output data changed");

    property p_shape_restart;
        @(posedge ref_clk) disable iff (rst)
        shape_write |=> env_cnt_q == ($past(start_up) ? 4'h0 : 4'hf) ##1 envelope_level_out == $past(env_cnt_q);
    endproperty
    a_shape_restart: assert property (p_shape_restart) else $error("shape write did not restart");

    property p_step_prescale;
        @(posedge ref_clk) disable iff (rst)
        env_step |-> prescale_q == PRESCALE_LAST;
    endproperty
    a_step_prescale: assert property (p_step_prescale) else $error("envelope step off prescaler");

    property p_hold_frozen;
        @(posedge ref_clk) disable iff (rst)
        (env_state_q == SGM_ENV_HOLD && !shape_write) |=> $stable(env_cnt_q);
    endproperty
    a_hold_frozen: assert property (p_hold_frozen) else $error("held envelope moved");

    property p_port_b_dir;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> general_port_b_oe == $past(mixer_port_enable_q[`SGM_MIX_PORT_B_DIR]);
    endproperty
    a_port_b_dir: assert property (p_port_b_dir) else $error("port B direction wrong");

    property p_prescale_count;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> prescale_q == $past(prescale_q) + 8'h01;
    endproperty
    a_prescale_count: assert property (p_prescale_count) else $error("prescaler skipped a count");

    property p_period_count;
        @(posedge ref_clk) disable iff (rst)
        (prescale_tick && !env_step && !shape_write) |=> period_cnt_q == $past(period_cnt_q) + 16'h0001;
    endproperty
    a_period_count: assert property (p_period_count) else $error("period counter did not advance");

    property p_hold_entry;
        @(posedge ref_clk) disable iff (rst)
        (env_state_q == SGM_ENV_HOLD && $past(env_state_q) == SGM_ENV_RUN) |-> env_cnt_q inside {4'h0, 4'hf};
    endproperty
    a_hold_entry: assert property (p_hold_entry) else $error("envelope held at a middle level");

    property p_port_a_drive;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> general_port_a_out == $past(port_a_data_store_q);
    endproperty
    a_port_a_drive: assert property (p_port_a_drive) else $error("port A pins not driven from store");

    property p_unused_read;
        @(posedge ref_clk) disable iff (rst)
        (addr_q < `SGM_REG_MIXER_PORT_ENABLE) |=> host_addr_data_bus_out == 8'h00;
    endproperty
    a_unused_read: assert property (p_unused_read) else $error("unused register did not read zero");
endmodule
`default_nettype wire
